// ---- hdl/dei_consts.svh ----
`ifndef DEI_CONSTS_SVH
`define DEI_CONSTS_SVH

// Configuration space byte addresses
`define DEI_OFF_POL 32'h60000008
`define DEI_OFF_EN_SET 32'h6000000C
`define DEI_OFF_EN_CLR 32'h60000010
`define DEI_OFF_HI_SEL 32'h60000014
`define DEI_OFF_LO_SEL 32'h60000018
`define DEI_OFF_FLAGS 32'h6000001C
`define DEI_OFF_MIRROR0 32'h60000034
`define DEI_OFF_CIRC0 32'h60000040
`define DEI_OFF_MIRROR1 32'h60000054
`define DEI_OFF_CIRC1 32'h60000060
`define DEI_OFF_MIRROR2 32'h60000074
`define DEI_OFF_DONE0 32'h60000080
`define DEI_OFF_MIRROR3 32'h60000094
`define DEI_OFF_DONE1 32'h600000A0
`define DEI_OFF_IRQ_MODE 32'h600000C0
`define DEI_OFF_STATUS 32'h600000C4
`define DEI_OFF_MASK 32'h600000C8
`define DEI_OFF_PINSEL0 32'h600000CC
`define DEI_OFF_PINSEL1 32'h600000D0
`define DEI_OFF_PINSEL2 32'h600000D4

// Status and mask bit positions
`define DEI_ST_HI_IRQ 0
`define DEI_ST_LO_IRQ 1
`define DEI_ST_WAIT 2

// Event input positions
`define DEI_EV_I2C_BASE 19
`define DEI_EV_RSVD 25
`define DEI_EV_ERR_BASE 26

// Reset values
`define DEI_RST_WORD 32'h00000000
`define DEI_RST_STAT 3'h0
`define DEI_RST_SEL 3'h0

`endif

// ---- hdl/dei_pkg.sv ----
package dei_pkg;
	typedef logic [31:0] dei_word_t;
	typedef logic [4:0] dei_evnum_t;
	typedef logic [2:0] dei_stat_t;
endpackage : dei_pkg

// ---- hdl/dei_top.sv ----
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "dei_consts.svh"

// Contract
// - A flagged, enabled event starts a transfer with no processor action.
// - Software toggles a trigger bit; the toggle reaches the event register as an edge.
// - Trigger bits 0,16,1,17,2,18,3,19,20,21 drive events 0,1,10,11,17,18,23,24,30,31.
// - Events 19..22 carry I2C port 0 and 1 transmit and receive requests.
// - Events 26..28 are OR of mute input, transmit and receive interrupts per port.
// - Each audio port selects its mute source from seven pins by a register.
// - A pin pulse of two or more cycles on the selected source raises an event.
// - An event marked for interrupt raises a processor interrupt, not a transfer.
// - A rising edge on the memory wait pin raises the non-maskable interrupt line.
// - The wait-pin interrupt is maskable and comes out of reset disabled.
// - The wait-pin interrupt always uses the rising edge, whatever wait polarity.
// - Trigger register sits on the core port only; event state is on the core port and also mapped at DEI_OFF_FLAGS.
// - Events are input transitions; polarity selects rising or falling capture.
// - Each event belongs to the high or low group, each with its own engine.
module dei_top #(
	parameter int PINS = 7,
	parameter int SELW = 3,
	parameter int PORTS = 3
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RESETN,
	input wire logic [31:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	input wire logic I_CORE_TRIG_WR,
	input wire logic [31:0] I_CORE_TRIG_WDATA,
	output logic [31:0] O_CORE_EVENT_STATE,
	input wire logic [3:0] I_RTI_REQ,
	input wire logic I_RTI_OVL,
	input wire logic [PORTS-1:0] I_AUDIO_TX_REQ,
	input wire logic [PORTS-1:0] I_AUDIO_RX_REQ,
	input wire logic [PORTS-1:0] I_AUDIO_TX_INT,
	input wire logic [PORTS-1:0] I_AUDIO_RX_INT,
	input wire logic I_HOST_INT,
	input wire logic [1:0] I_SPI_RX_REQ,
	input wire logic [1:0] I_I2C_TX_REQ,
	input wire logic [1:0] I_I2C_RX_REQ,
	input wire logic [PINS-1:0] I_IO_PIN,
	input wire logic I_EXTERNAL_MEMORY_WAIT_PIN,
	input wire logic [31:0] I_CIRC_STATE0,
	input wire logic [31:0] I_CIRC_STATE1,
	input wire logic I_HI_BUSY,
	input wire logic I_LO_BUSY,
	input wire logic I_HI_DONE,
	input wire logic I_LO_DONE,
	output logic O_HI_START,
	output logic [4:0] O_HI_EVENT,
	output logic O_LO_START,
	output logic [4:0] O_LO_EVENT,
	output logic O_IRQ,
	output logic O_NONMASKABLE_INTERRUPT_LINE
);

	dei_pkg::dei_word_t trig_reg, pol_reg, en_reg, grp_reg, flags_reg, irqmode_reg;
	dei_pkg::dei_word_t level_reg, prev_reg, done0_reg, done1_reg;
	dei_pkg::dei_word_t ev_in, edge_w, flags_next, hi_pend, lo_pend, started;
	dei_pkg::dei_stat_t stat_reg, mask_reg, stat_set;
	logic [SELW-1:0] sel_reg [PORTS];
	logic [PINS-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
	logic [PORTS-1:0] mute_lvl;
	logic wait_s1_reg, wait_s2_reg, wait_s3_reg, wait_lvl_reg, wait_rise;
	logic hi_valid, lo_valid, hi_is_irq, lo_is_irq, hi_go, lo_go;
	dei_pkg::dei_evnum_t hi_num, lo_num;
	logic wr_pol, wr_en_set, wr_en_clr, wr_hi, wr_lo, wr_flags, wr_irqmode;
	logic wr_stat, wr_mask, wr_done0, wr_done1;

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESETN);

	// Write decode, one register per address
	assign wr_pol = I_WR && (I_ADDR == `DEI_OFF_POL);
	assign wr_en_set = I_WR && (I_ADDR == `DEI_OFF_EN_SET);
	assign wr_en_clr = I_WR && (I_ADDR == `DEI_OFF_EN_CLR);
	assign wr_hi = I_WR && (I_ADDR == `DEI_OFF_HI_SEL);
	assign wr_lo = I_WR && (I_ADDR == `DEI_OFF_LO_SEL);
	assign wr_flags = I_WR && (I_ADDR == `DEI_OFF_FLAGS);
	assign wr_irqmode = I_WR && (I_ADDR == `DEI_OFF_IRQ_MODE);
	assign wr_stat = I_WR && (I_ADDR == `DEI_OFF_STATUS);
	assign wr_mask = I_WR && (I_ADDR == `DEI_OFF_MASK);
	assign wr_done0 = I_WR && (I_ADDR == `DEI_OFF_DONE0);
	assign wr_done1 = I_WR && (I_ADDR == `DEI_OFF_DONE1);

	// Trigger register lives on the core port only
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			trig_reg <= `DEI_RST_WORD;
		end else if (I_CORE_TRIG_WR) begin
			trig_reg <= I_CORE_TRIG_WDATA;
		end
	end

	// Configuration registers; enable and group use set/clear pairs so no read-modify-write race
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			pol_reg <= `DEI_RST_WORD;
			en_reg <= `DEI_RST_WORD;
			grp_reg <= `DEI_RST_WORD;
			irqmode_reg <= `DEI_RST_WORD;
			mask_reg <= `DEI_RST_STAT;
		end else begin
			if (wr_pol) begin
				pol_reg <= I_WDATA;
			end
			if (wr_en_set) begin
				en_reg <= en_reg | I_WDATA;
			end
			if (wr_en_clr) begin
				en_reg <= en_reg & ~I_WDATA;
			end
			if (wr_hi) begin
				grp_reg <= grp_reg | I_WDATA;
			end
			if (wr_lo) begin
				grp_reg <= grp_reg & ~I_WDATA;
			end
			if (wr_irqmode) begin
				irqmode_reg <= I_WDATA;
			end
			if (wr_mask) begin
				mask_reg <= I_WDATA[2:0];
			end
		end
	end

	// Mute source selects, one per audio port
	generate
		for (genvar g = 0; g < PORTS; g++) begin : g_port
			always_ff @(posedge I_CLK_SYS) begin
				if (!I_RESETN) begin
					sel_reg[g] <= `DEI_RST_SEL;
				end else if (I_WR && (I_ADDR == `DEI_OFF_PINSEL0 + 32'(4 * g))) begin
					sel_reg[g] <= I_WDATA[SELW-1:0];
				end
			end
			// Out-of-range selects give a quiet source
			assign mute_lvl[g] = (int'(sel_reg[g]) < PINS) ? pin_lvl_reg[sel_reg[g]] : 1'b0;
		end
	endgenerate

	// Pin synchronisers; a level counts only once two stages agree
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
			pin_lvl_reg <= '0;
		end else begin
			pin_s1_reg <= I_IO_PIN;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_lvl_reg <= (pin_s2_reg & pin_s3_reg) | (pin_lvl_reg & (pin_s2_reg | pin_s3_reg));
		end
	end

	// Wait pin synchroniser, same filtering
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			wait_s1_reg <= 1'b0;
			wait_s2_reg <= 1'b0;
			wait_s3_reg <= 1'b0;
			wait_lvl_reg <= 1'b0;
		end else begin
			wait_s1_reg <= I_EXTERNAL_MEMORY_WAIT_PIN;
			wait_s2_reg <= wait_s1_reg;
			wait_s3_reg <= wait_s2_reg;
			if (wait_s2_reg == wait_s3_reg) begin
				wait_lvl_reg <= wait_s3_reg;
			end
		end
	end

	// Filtered pin, rising only: stretching polarity is never consulted here
	assign wait_rise = wait_s2_reg && wait_s3_reg && !wait_lvl_reg;

	// Event input assembly
	always_comb begin
		ev_in = '0;
		ev_in[0] = trig_reg[0];
		ev_in[1] = trig_reg[16];
		ev_in[3:2] = I_RTI_REQ[1:0];
		ev_in[4] = I_AUDIO_TX_REQ[0];
		ev_in[5] = I_AUDIO_RX_REQ[0];
		ev_in[6] = I_AUDIO_TX_REQ[1];
		ev_in[7] = I_AUDIO_RX_REQ[1];
		ev_in[8] = I_AUDIO_TX_REQ[2];
		ev_in[9] = I_AUDIO_RX_REQ[2];
		ev_in[10] = trig_reg[1];
		ev_in[11] = trig_reg[17];
		ev_in[12] = I_HOST_INT;
		ev_in[14:13] = I_SPI_RX_REQ;
		ev_in[16:15] = I_RTI_REQ[3:2];
		ev_in[17] = trig_reg[2];
		ev_in[18] = trig_reg[18];
		ev_in[`DEI_EV_I2C_BASE] = I_I2C_TX_REQ[0];
		ev_in[`DEI_EV_I2C_BASE + 1] = I_I2C_RX_REQ[0];
		ev_in[`DEI_EV_I2C_BASE + 2] = I_I2C_TX_REQ[1];
		ev_in[`DEI_EV_I2C_BASE + 3] = I_I2C_RX_REQ[1];
		ev_in[23] = trig_reg[3];
		ev_in[24] = trig_reg[19];
		ev_in[`DEI_EV_RSVD] = 1'b0;
		for (int p = 0; p < PORTS; p++) begin
			ev_in[`DEI_EV_ERR_BASE + p] = mute_lvl[p] | I_AUDIO_TX_INT[p] | I_AUDIO_RX_INT[p];
		end
		ev_in[29] = I_RTI_OVL;
		ev_in[30] = trig_reg[20];
		ev_in[31] = trig_reg[21];
	end

	// Level mirror and previous level for edge detection
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			level_reg <= `DEI_RST_WORD;
			prev_reg <= `DEI_RST_WORD;
		end else begin
			level_reg <= ev_in;
			prev_reg <= level_reg;
		end
	end

	// Polarity 0 captures rising, 1 captures falling
	assign edge_w = en_reg & (level_reg ^ prev_reg) & (level_reg ^ pol_reg);

	// Lowest pending index wins within each group
	always_comb begin
		hi_pend = flags_reg & grp_reg;
		lo_pend = flags_reg & ~grp_reg;
		hi_valid = |hi_pend;
		lo_valid = |lo_pend;
		hi_num = '0;
		lo_num = '0;
		for (int i = 31; i >= 0; i--) begin
			if (hi_pend[i]) begin
				hi_num = 5'(i);
			end
			if (lo_pend[i]) begin
				lo_num = 5'(i);
			end
		end
	end

	// Interrupt-mode entries bypass the engine, so they never wait on busy
	assign hi_is_irq = irqmode_reg[hi_num];
	assign lo_is_irq = irqmode_reg[lo_num];
	assign hi_go = hi_valid && (hi_is_irq || (!I_HI_BUSY && !O_HI_START));
	assign lo_go = lo_valid && (lo_is_irq || (!I_LO_BUSY && !O_LO_START));
	always_comb begin
		started = '0;
		if (hi_go) begin
			started[hi_num] = 1'b1;
		end
		if (lo_go) begin
			started[lo_num] = 1'b1;
		end
	end

	// Capture flags; a new edge beats any clear in the same cycle
	assign flags_next = (flags_reg & ~started & ~(wr_flags ? I_WDATA : '0)) | edge_w;
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			flags_reg <= `DEI_RST_WORD;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Engine start pulses, one per group
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			O_HI_START <= 1'b0;
			O_LO_START <= 1'b0;
			O_HI_EVENT <= '0;
			O_LO_EVENT <= '0;
		end else begin
			O_HI_START <= hi_go && !hi_is_irq;
			O_LO_START <= lo_go && !lo_is_irq;
			if (hi_go && !hi_is_irq) begin
				O_HI_EVENT <= hi_num;
			end
			if (lo_go && !lo_is_irq) begin
				O_LO_EVENT <= lo_num;
			end
		end
	end

	// Completion flags, tagged by the event last started
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			done0_reg <= `DEI_RST_WORD;
			done1_reg <= `DEI_RST_WORD;
		end else begin
			done0_reg <= (done0_reg & ~(wr_done0 ? I_WDATA : '0)) | (I_HI_DONE ? (32'h00000001 << O_HI_EVENT) : '0);
			done1_reg <= (done1_reg & ~(wr_done1 ? I_WDATA : '0)) | (I_LO_DONE ? (32'h00000001 << O_LO_EVENT) : '0);
		end
	end

	// Sticky status, write one to clear, set wins
	always_comb begin
		stat_set = '0;
		stat_set[`DEI_ST_HI_IRQ] = hi_go && hi_is_irq;
		stat_set[`DEI_ST_LO_IRQ] = lo_go && lo_is_irq;
		stat_set[`DEI_ST_WAIT] = wait_rise;
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			stat_reg <= `DEI_RST_STAT;
		end else begin
			stat_reg <= (stat_reg & ~(wr_stat ? I_WDATA[2:0] : 3'h0)) | stat_set;
		end
	end

	// Interrupt outputs; the wait source feeds only the non-maskable line
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			O_IRQ <= 1'b0;
			O_NONMASKABLE_INTERRUPT_LINE <= 1'b0;
		end else begin
			O_IRQ <= |(stat_reg[1:0] & mask_reg[1:0]);
			O_NONMASKABLE_INTERRUPT_LINE <= stat_reg[`DEI_ST_WAIT] && mask_reg[`DEI_ST_WAIT];
		end
	end

	// Read port; data stands only in the cycle after the strobe
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			O_RDATA <= `DEI_RST_WORD;
			O_CORE_EVENT_STATE <= `DEI_RST_WORD;
		end else begin
			O_CORE_EVENT_STATE <= flags_reg;
			O_RDATA <= `DEI_RST_WORD;
			if (I_RD) begin
				case (I_ADDR)
					`DEI_OFF_POL: O_RDATA <= pol_reg;
					`DEI_OFF_EN_SET, `DEI_OFF_EN_CLR: O_RDATA <= en_reg;
					`DEI_OFF_HI_SEL: O_RDATA <= grp_reg;
					`DEI_OFF_LO_SEL: O_RDATA <= ~grp_reg;
					`DEI_OFF_FLAGS: O_RDATA <= flags_reg;
					`DEI_OFF_MIRROR0, `DEI_OFF_MIRROR1, `DEI_OFF_MIRROR2, `DEI_OFF_MIRROR3: O_RDATA <= level_reg;
					`DEI_OFF_CIRC0: O_RDATA <= I_CIRC_STATE0;
					`DEI_OFF_CIRC1: O_RDATA <= I_CIRC_STATE1;
					`DEI_OFF_DONE0: O_RDATA <= done0_reg;
					`DEI_OFF_DONE1: O_RDATA <= done1_reg;
					`DEI_OFF_IRQ_MODE: O_RDATA <= irqmode_reg;
					`DEI_OFF_STATUS: O_RDATA <= {29'h00000000, stat_reg};
					`DEI_OFF_MASK: O_RDATA <= {29'h00000000, mask_reg};
					`DEI_OFF_PINSEL0: O_RDATA <= 32'(sel_reg[0]);
					`DEI_OFF_PINSEL1: O_RDATA <= 32'(sel_reg[1]);
					`DEI_OFF_PINSEL2: O_RDATA <= 32'(sel_reg[2]);
					default: O_RDATA <= `DEI_RST_WORD;
				endcase
			end
		end
	end

	property p_trig_map;
		level_reg[0] == $past(trig_reg[0]) && level_reg[1] == $past(trig_reg[16]) && level_reg[31] == $past(trig_reg[21]);
	endproperty
	a_trig_map: assert property (p_trig_map) else $error("trigger bit not mirrored");

	property p_rsvd;
		level_reg[`DEI_EV_RSVD] == 1'b0 && flags_reg[`DEI_EV_RSVD] == 1'b0 && !(O_HI_START && O_HI_EVENT == 5'h19);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved event active");

	property p_edge_flag;
		(edge_w != 32'h00000000) |=> ((flags_reg & $past(edge_w)) == $past(edge_w));
	endproperty
	a_edge_flag: assert property (p_edge_flag) else $error("edge not captured");

	property p_hi_start;
		(hi_valid && !hi_is_irq && !I_HI_BUSY && !O_HI_START) |=> (O_HI_START && O_HI_EVENT == $past(hi_num));
	endproperty
	a_hi_start: assert property (p_hi_start) else $error("high group start missing");

	property p_irq_mode;
		(lo_valid && lo_is_irq) |=> (!O_LO_START && stat_reg[`DEI_ST_LO_IRQ])
			##1 (O_IRQ || !$past(mask_reg[`DEI_ST_LO_IRQ]));
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("interrupt entry misrouted");

	property p_wait_nmi;
		(wait_rise && mask_reg[`DEI_ST_WAIT] && !wr_mask) |=> ##1 O_NONMASKABLE_INTERRUPT_LINE;
	endproperty
	a_wait_nmi: assert property (p_wait_nmi) else $error("wait edge lost");

	property p_nmi_masked;
		!mask_reg[`DEI_ST_WAIT] |=> !O_NONMASKABLE_INTERRUPT_LINE;
	endproperty
	a_nmi_masked: assert property (p_nmi_masked) else $error("masked wait interrupt seen");

	property p_err_or;
		level_reg[`DEI_EV_ERR_BASE] == $past(mute_lvl[0] | I_AUDIO_TX_INT[0] | I_AUDIO_RX_INT[0]);
	endproperty
	a_err_or: assert property (p_err_or) else $error("audio error merge wrong");

	property p_i2c;
		level_reg[`DEI_EV_I2C_BASE + 3:`DEI_EV_I2C_BASE] == $past({I_I2C_RX_REQ[1], I_I2C_TX_REQ[1], I_I2C_RX_REQ[0], I_I2C_TX_REQ[0]});
	endproperty
	a_i2c: assert property (p_i2c) else $error("i2c event mapping wrong");

endmodule : dei_top

// ---- tb/dei_partner.sv ----
`timescale 1ns/10ps
// Stand-in for the two address engines: busy for LAT cycles per start
module dei_partner #(
	parameter int LAT = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_hi_start,
	input wire logic i_lo_start,
	output logic o_hi_busy,
	output logic o_lo_busy,
	output logic o_hi_done,
	output logic o_lo_done
);
	logic [7:0] hi_cnt_reg;
	logic [7:0] lo_cnt_reg;

	// High group engine, independent of the low one
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn)
			hi_cnt_reg <= 8'h00;
		else if (i_hi_start)
			hi_cnt_reg <= 8'(LAT);
		else if (hi_cnt_reg != 8'h00)
			hi_cnt_reg <= hi_cnt_reg - 8'h01;
	end

	// Low group engine
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn)
			lo_cnt_reg <= 8'h00;
		else if (i_lo_start)
			lo_cnt_reg <= 8'(LAT);
		else if (lo_cnt_reg != 8'h00)
			lo_cnt_reg <= lo_cnt_reg - 8'h01;
	end

	// Busy covers the whole window, done is its last cycle
	assign o_hi_busy = (hi_cnt_reg != 8'h00);
	assign o_lo_busy = (lo_cnt_reg != 8'h00);
	assign o_hi_done = (hi_cnt_reg == 8'h01);
	assign o_lo_done = (lo_cnt_reg == 8'h01);
endmodule : dei_partner

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`include "dei_consts.svh"
module testbench;
	logic clk, rst_n, wr_s, rd_s, ctw, host, ovl, hi_start, lo_start, irq, nmi, wpin;
	logic hi_busy, lo_busy, hi_done, lo_done;
	logic [31:0] addr, wdata, rdata, ctwd, evstate, trig_val;
	logic [3:0] rti;
	logic [2:0] aud_txq, aud_rxq, aud_tx, aud_rx;
	logic [1:0] spi, i2c_tx, i2c_rx;
	logic [6:0] pins;
	logic [4:0] hi_ev, lo_ev;
	int miscompares, checks_done;
	int tbit[8] = '{1, 17, 2, 18, 3, 19, 20, 21};
	int tev[8] = '{10, 11, 17, 18, 23, 24, 30, 31};
	int pev[13] = '{19, 20, 21, 22, 26, 27, 28, 2, 29, 4, 9, 12, 14};

	dei_top DUT (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
		.O_RDATA(rdata), .I_CORE_TRIG_WR(ctw), .I_CORE_TRIG_WDATA(ctwd), .O_CORE_EVENT_STATE(evstate),
		.I_RTI_REQ(rti), .I_RTI_OVL(ovl), .I_AUDIO_TX_REQ(aud_txq), .I_AUDIO_RX_REQ(aud_rxq),
		.I_AUDIO_TX_INT(aud_tx), .I_AUDIO_RX_INT(aud_rx), .I_HOST_INT(host), .I_SPI_RX_REQ(spi),
		.I_I2C_TX_REQ(i2c_tx), .I_I2C_RX_REQ(i2c_rx), .I_IO_PIN(pins), .I_EXTERNAL_MEMORY_WAIT_PIN(wpin),
		.I_CIRC_STATE0(32'h0000A5A5), .I_CIRC_STATE1(32'h00005A5A), .I_HI_BUSY(hi_busy), .I_LO_BUSY(lo_busy),
		.I_HI_DONE(hi_done), .I_LO_DONE(lo_done), .O_HI_START(hi_start), .O_HI_EVENT(hi_ev),
		.O_LO_START(lo_start), .O_LO_EVENT(lo_ev), .O_IRQ(irq), .O_NONMASKABLE_INTERRUPT_LINE(nmi));

	dei_partner #(.LAT(4)) u_engines (.i_clk_sys(clk), .i_resetn(rst_n), .i_hi_start(hi_start),
		.i_lo_start(lo_start), .o_hi_busy(hi_busy), .o_lo_busy(lo_busy), .o_hi_done(hi_done), .o_lo_done(lo_done));

	// Free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	// Read data is only valid in the cycle right after the strobe
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic trig_flip(input logic [31:0] bits);
		trig_val = trig_val ^ bits;
		@(posedge clk);
		ctw <= 1'b1;
		ctwd <= trig_val;
		@(posedge clk);
		ctw <= 1'b0;
	endtask : trig_flip

	function automatic logic pick(input int sel);
		case (sel)
			0: return irq;
			1: return nmi;
			2: return hi_start;
			default: return lo_start;
		endcase
	endfunction : pick

	// Bounded wait; a stuck output ends the run as a failure
	task automatic wait_flag(input int sel);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		while (pick(sel) !== 1'b1) begin
			n++;
			if (n > 40) begin
				$display("BAD wait on output %0d expected 1 seen timeout", sel);
				miscompares++;
				tally_and_finish();
			end
			@(posedge clk);
			#1;
		end
	endtask : wait_flag

	task automatic wait_start(input int sel, input logic [4:0] ev);
		wait_flag(sel);
		chk("start event", {27'h0, ev}, {27'h0, (sel == 2) ? hi_ev : lo_ev});
	endtask : wait_start

	// One-cycle pulse on a peripheral event source
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: i2c_tx[0] <= 1'b1;
			1: i2c_rx[0] <= 1'b1;
			2: i2c_tx[1] <= 1'b1;
			3: i2c_rx[1] <= 1'b1;
			4: aud_tx[0] <= 1'b1;
			5: aud_rx[1] <= 1'b1;
			6: aud_tx[2] <= 1'b1;
			7: rti[0] <= 1'b1;
			8: ovl <= 1'b1;
			9: aud_txq[0] <= 1'b1;
			10: aud_rxq[2] <= 1'b1;
			11: host <= 1'b1;
			default: spi[1] <= 1'b1;
		endcase
		@(posedge clk);
		{i2c_tx, i2c_rx, aud_tx, aud_rx, rti, ovl, aud_txq, aud_rxq, host, spi} <= '0;
	endtask : pulse

	task automatic ev_case(input int ev, input int k, input int b);
		wr(`DEI_OFF_EN_SET, 32'h1 << ev);
		if (b >= 0)
			trig_flip(32'h1 << b);
		else
			pulse(k);
		wait_start(3, 5'(ev));
		wr(`DEI_OFF_EN_CLR, 32'h1 << ev);
	endtask : ev_case

	task automatic t_reset();
		logic [31:0] a[11] = '{`DEI_OFF_POL, `DEI_OFF_EN_SET, `DEI_OFF_HI_SEL, `DEI_OFF_LO_SEL, `DEI_OFF_FLAGS,
			`DEI_OFF_STATUS, `DEI_OFF_MASK, `DEI_OFF_IRQ_MODE, `DEI_OFF_PINSEL0, 32'h60000004, `DEI_OFF_CIRC0};
		logic [31:0] e[11] = '{32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000A5A5};
		logic [31:0] d;
		for (int i = 0; i < 11; i++) begin
			rd(a[i], d);
			chk("reset register", e[i], d);
		end
		chk("nmi after reset", 32'h0, {31'h0, nmi});
		$display("test reset done");
	endtask : t_reset

	// Two software events at once in the high group: lowest number first
	task automatic t_priority();
		logic [31:0] d;
		wr(`DEI_OFF_HI_SEL, 32'h00000003);
		wr(`DEI_OFF_EN_SET, 32'h00000003);
		trig_flip(32'h00010001);
		wait_start(2, 5'h00);
		// Event 1 still waits behind the busy engine, event 0 already taken
		@(posedge clk);
		#1;
		chk("core event state", 32'h00000002, evstate);
		wait_start(2, 5'h01);
		wr(`DEI_OFF_LO_SEL, 32'h00000003);
		wr(`DEI_OFF_EN_CLR, 32'h00000003);
		rd(`DEI_OFF_DONE0, d);
		chk("high group done flags", 32'h00000003, d);
		$display("test priority done");
	endtask : t_priority

	task automatic t_table();
		logic [31:0] d;
		for (int i = 0; i < 8; i++)
			ev_case(tev[i], 0, tbit[i]);
		// One source per merged audio event is driven alone, so the bench knows which one fired
		for (int i = 0; i < 13; i++)
			ev_case(pev[i], i, -1);
		// Let the last transfer finish before looking at the completion flags
		repeat (2) @(posedge clk);
		rd(`DEI_OFF_DONE1, d);
		chk("low group done flags", 32'hFDFE5E14, d);
		$display("test event table done");
	endtask : t_table

	// Trigger bit 1 is high now, so flipping it is a falling edge
	task automatic t_polarity();
		wr(`DEI_OFF_POL, 32'h00000400);
		ev_case(10, 0, 1);
		wr(`DEI_OFF_POL, 32'h00000000);
		$display("test polarity done");
	endtask : t_polarity

	task automatic t_mute();
		wr(`DEI_OFF_PINSEL0, 32'h00000004);
		wr(`DEI_OFF_EN_SET, 32'h04000000);
		@(posedge clk);
		pins[4] <= 1'b1;
		repeat (2) @(posedge clk);
		pins[4] <= 1'b0;
		wait_start(3, 5'd26);
		wr(`DEI_OFF_EN_CLR, 32'h04000000);
		$display("test mute pin done");
	endtask : t_mute

	task automatic t_irq();
		logic [31:0] d;
		int stray;
		stray = 0;
		wr(`DEI_OFF_IRQ_MODE, 32'h00080000);
		wr(`DEI_OFF_EN_SET, 32'h00080000);
		pulse(0);
		repeat (8) begin
			@(posedge clk);
			#1;
			stray += (lo_start === 1'b1) ? 1 : 0;
		end
		chk("start in interrupt mode", 32'h0, 32'(stray));
		chk("masked irq", 32'h0, {31'h0, irq});
		rd(`DEI_OFF_STATUS, d);
		chk("low group status", 32'h00000002, d);
		wr(`DEI_OFF_MASK, 32'h00000002);
		wait_flag(0);
		wr(`DEI_OFF_STATUS, 32'h00000002);
		repeat (2) @(posedge clk);
		#1;
		chk("irq after clear", 32'h0, {31'h0, irq});
		wr(`DEI_OFF_EN_CLR, 32'h00080000);
		wr(`DEI_OFF_IRQ_MODE, 32'h00000000);
		$display("test interrupt mode done");
	endtask : t_irq

	task automatic t_wait();
		logic [31:0] d;
		@(posedge clk);
		wpin <= 1'b1;
		repeat (4) @(posedge clk);
		wpin <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk("nmi while masked", 32'h0, {31'h0, nmi});
		rd(`DEI_OFF_STATUS, d);
		chk("wait status", 32'h00000004, d);
		wr(`DEI_OFF_STATUS, 32'h00000004);
		wr(`DEI_OFF_MASK, 32'h00000004);
		@(posedge clk);
		wpin <= 1'b1;
		wait_flag(1);
		wr(`DEI_OFF_STATUS, 32'h00000004);
		repeat (2) @(posedge clk);
		#1;
		chk("nmi after clear", 32'h0, {31'h0, nmi});
		@(posedge clk);
		wpin <= 1'b0;
		repeat (8) @(posedge clk);
		rd(`DEI_OFF_STATUS, d);
		chk("status on falling wait", 32'h0, d);
		$display("test wait pin done");
	endtask : t_wait

	task automatic t_rsvd();
		logic [31:0] d;
		wr(`DEI_OFF_EN_SET, 32'h02000000);
		repeat (4) @(posedge clk);
		rd(`DEI_OFF_FLAGS, d);
		chk("reserved flag", 32'h0, d & 32'h02000000);
		rd(`DEI_OFF_MIRROR0, d);
		chk("reserved level", 32'h0, d & 32'h02000000);
		$display("test reserved event done");
	endtask : t_rsvd

	// Main sequence: all inputs quiet at time zero, reset for 3 cycles
	initial begin
		{rst_n, wr_s, rd_s, ctw, host, ovl, wpin, rti, aud_txq, aud_rxq, aud_tx, aud_rx, spi, i2c_tx, i2c_rx} = '0;
		{addr, wdata, ctwd, trig_val, pins} = '0;
		miscompares = 0;
		checks_done = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_priority();
		t_table();
		t_polarity();
		t_mute();
		t_irq();
		t_wait();
		t_rsvd();
		tally_and_finish();
	end
endmodule : testbench
